// *** logic/nvcd_top.sv ***
// Nonvolatile configuration word store, read port and reset-time decoder
`timescale 1ns/10ps
module nvcd_top
    import nvcd_pkg::*;
#(
    parameter int FLASH_SIZE_W = 16,
    // Per-variant flash protection sizes, entry n at [n*W +: W]
    parameter logic [8*FLASH_SIZE_W-1:0] BOOT_FLASH_TABLE = '0,
    parameter logic [8*FLASH_SIZE_W-1:0] SECURE_FLASH_TABLE = '0
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Program-memory read port
    input wire logic rd_en_i,
    input wire logic [23:0] rd_addr_i,
    output logic rd_valid_o,
    output logic [23:0] rd_data_o,
    // Programming port
    input wire logic pgm_en_i,
    input wire logic pgm_erase_i,
    input wire logic [1:0] pgm_src_i,
    input wire logic [23:0] pgm_addr_i,
    input wire logic [23:0] pgm_data_i,
    output logic pgm_done_o,
    output logic pgm_error_o,
    // Code protection decodes
    output logic [10:0] boot_ram_size_o,
    output logic [FLASH_SIZE_W-1:0] boot_flash_protect_size_o,
    output logic boot_write_protect_n_o,
    output logic [12:0] secure_ram_size_o,
    output logic [FLASH_SIZE_W-1:0] secure_flash_protect_size_o,
    output logic secure_write_protect_n_o,
    output logic [1:0] general_protect_level_o,
    output logic general_write_protect_n_o,
    // Oscillator decodes
    output logic two_speed_startup_en_o,
    output logic [2:0] initial_clock_source_o,
    output logic clock_switch_en_o,
    output logic fail_safe_clock_monitor_o,
    output logic pin_map_single_change_o,
    output logic osc_out_clock_en_o,
    output logic osc_out_gpio_en_o,
    output logic [1:0] primary_osc_mode_o
);

    //=================================================================
    // Elaboration checks
    if (FLASH_SIZE_W < 1 || FLASH_SIZE_W > 24)
    begin : g_bad_width
        $error("FLASH_SIZE_W must be 1 to 24");
    end

    //=================================================================
    // Helpers

    // Map an address onto a word index; index 7 means unmapped
    function automatic logic [2:0] word_index(input logic [23:0] addr);
        logic [23:0] off;
        off = addr - NVCD_BASE_ADDR;
        word_index = 3'h7;
        if (addr >= NVCD_BASE_ADDR && off[0] == 1'b0
            && off < 24'(NVCD_WORD_COUNT * NVCD_ADDR_STEP))
        begin
            word_index = off[3:1];
        end
    endfunction

    // Implemented bits of each word; the rest always read zero
    function automatic logic [23:0] word_mask(input logic [2:0] idx);
        case (idx)
            NVCD_IDX_BOOT: word_mask = NVCD_MASK_BOOT;
            NVCD_IDX_SECURE: word_mask = NVCD_MASK_SECURE;
            NVCD_IDX_GENERAL: word_mask = NVCD_MASK_GENERAL;
            NVCD_IDX_OSC_SEL: word_mask = NVCD_MASK_OSC_SEL;
            NVCD_IDX_OSC: word_mask = NVCD_MASK_OSC;
            default: word_mask = 24'h000000;
        endcase
    endfunction

    // Per-variant table lookup for the three-bit flash size fields
    function automatic logic [FLASH_SIZE_W-1:0] flash_size(
        input logic [8*FLASH_SIZE_W-1:0] table_in,
        input logic [2:0] code
    );
        flash_size = table_in[code*FLASH_SIZE_W +: FLASH_SIZE_W];
    endfunction

    //=================================================================
    // Nonvolatile word store
    // The cells are not touched by reset: they model flash that keeps
    // its contents across power-down, and they come up erased.
    logic [23:0] cfg_word [NVCD_WORD_COUNT] = '{default: NVCD_ERASED};
    logic [23:0] next_cfg_word [NVCD_WORD_COUNT];
    logic next_pgm_done;
    logic next_pgm_error;
    logic pgm_done;
    logic pgm_error;
    logic [2:0] pgm_idx;
    logic pgm_src_ok;

    // Programming can only clear bits; erase restores every word
    always_comb
    begin
        pgm_idx = word_index(pgm_addr_i);
        pgm_src_ok = pgm_src_i == NVCD_PGM_SELF || pgm_src_i == NVCD_PGM_SERIAL
            || pgm_src_i == NVCD_PGM_PROGRAMMER;
        next_cfg_word = cfg_word;
        next_pgm_done = 1'b0;
        next_pgm_error = 1'b0;
        if (pgm_erase_i && pgm_src_ok)
        begin
            next_cfg_word = '{default: NVCD_ERASED};
            next_pgm_done = 1'b1;
        end
        else if (pgm_en_i)
        begin
            if (pgm_src_ok && pgm_idx != 3'h7)
            begin
                // Only low 16 bits are stored, upper byte never holds data
                next_cfg_word[pgm_idx] = cfg_word[pgm_idx]
                    & (pgm_data_i | ~NVCD_ERASED);
                next_pgm_done = 1'b1;
            end
            else
            begin
                next_pgm_error = 1'b1;
            end
        end
        else if (pgm_erase_i)
        begin
            next_pgm_error = 1'b1;
        end
    end

    // Store update; status pulses are cleared by reset, the cells are not
    always_ff @(posedge clk_i)
    begin
        cfg_word <= next_cfg_word;
        if (!reset_n_i)
        begin
            pgm_done <= 1'b0;
            pgm_error <= 1'b0;
        end
        else
        begin
            pgm_done <= next_pgm_done;
            pgm_error <= next_pgm_error;
        end
    end

    assign pgm_done_o = pgm_done;
    assign pgm_error_o = pgm_error;

    //=================================================================
    // Run-time read port
    logic [2:0] rd_idx;
    logic [23:0] next_rd_data;
    logic next_rd_valid;
    logic [23:0] rd_data;
    logic rd_valid;

    // Unmapped addresses answer zero rather than stalling the fetch
    always_comb
    begin
        rd_idx = word_index(rd_addr_i);
        next_rd_valid = rd_en_i;
        next_rd_data = rd_data;
        if (rd_en_i)
        begin
            next_rd_data = 24'h000000;
            if (rd_idx != 3'h7)
            begin
                next_rd_data = cfg_word[rd_idx] & word_mask(rd_idx);
            end
        end
    end

    // Read data register
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            rd_valid <= 1'b0;
            rd_data <= 24'h000000;
        end
        else
        begin
            rd_valid <= next_rd_valid;
            rd_data <= next_rd_data;
        end
    end

    assign rd_valid_o = rd_valid;
    assign rd_data_o = rd_data;

    //=================================================================
    // Field decode from the stored words
    logic [23:0] w_boot;
    logic [23:0] w_sec;
    logic [23:0] w_gen;
    logic [23:0] w_sel;
    logic [23:0] w_osc;
    logic [10:0] dec_boot_ram;
    logic [12:0] dec_sec_raw;
    logic [12:0] dec_sec_ram;
    logic [1:0] dec_gen_level;
    logic [1:0] dec_switch_mode;
    logic [1:0] dec_pri_mode;
    logic dec_crystal;

    always_comb
    begin
        w_boot = cfg_word[NVCD_IDX_BOOT];
        w_sec = cfg_word[NVCD_IDX_SECURE];
        w_gen = cfg_word[NVCD_IDX_GENERAL];
        w_sel = cfg_word[NVCD_IDX_OSC_SEL];
        w_osc = cfg_word[NVCD_IDX_OSC];
        case (w_boot[NVCD_RAM_SIZE_LSB +: 2])
            2'h3: dec_boot_ram = NVCD_BOOT_RAM_NONE;
            2'h2: dec_boot_ram = NVCD_BOOT_RAM_128;
            2'h1: dec_boot_ram = NVCD_BOOT_RAM_256;
            default: dec_boot_ram = NVCD_BOOT_RAM_1024;
        endcase
        case (w_sec[NVCD_RAM_SIZE_LSB +: 2])
            2'h3: dec_sec_raw = NVCD_SEC_RAM_NONE;
            2'h2: dec_sec_raw = NVCD_SEC_RAM_256;
            2'h1: dec_sec_raw = NVCD_SEC_RAM_2048;
            default: dec_sec_raw = NVCD_SEC_RAM_4096;
        endcase
        // Boot RAM comes out of the secure area; clamp so it never wraps
        if (dec_sec_raw > {2'h0, dec_boot_ram})
        begin
            dec_sec_ram = dec_sec_raw - {2'h0, dec_boot_ram};
        end
        else
        begin
            dec_sec_ram = 13'h0000;
        end
        case (w_gen[NVCD_GEN_LEVEL_LSB +: 2])
            2'h3: dec_gen_level = NVCD_PROT_NONE;
            2'h2: dec_gen_level = NVCD_PROT_STANDARD;
            default: dec_gen_level = NVCD_PROT_HIGH;
        endcase
        dec_switch_mode = w_osc[NVCD_SWITCH_MODE_LSB +: 2];
        dec_pri_mode = w_osc[NVCD_PRI_MODE_LSB +: 2];
        dec_crystal = dec_pri_mode == NVCD_PRI_STD_CRYSTAL
            || dec_pri_mode == NVCD_PRI_HS_CRYSTAL;
    end

    //=================================================================
    // Captured configuration: sampled while reset is held, frozen after
    // Freezing keeps a later self-programming pass from shifting clocks
    // or protection under running code; new values need another reset.
    logic [10:0] boot_ram;
    logic [FLASH_SIZE_W-1:0] boot_flash;
    logic boot_wr;
    logic [12:0] sec_ram;
    logic [FLASH_SIZE_W-1:0] sec_flash;
    logic sec_wr;
    logic [1:0] gen_level;
    logic gen_wr;
    logic two_speed;
    logic [2:0] clk_src;
    logic switch_en;
    logic fail_safe_clock_monitor_en;
    logic pin_lock;
    logic osc_clk;
    logic osc_gpio;
    logic [1:0] pri_mode;

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            boot_ram <= dec_boot_ram;
            boot_flash <= flash_size(BOOT_FLASH_TABLE,
                w_boot[NVCD_FLASH_SIZE_LSB +: 3]);
            boot_wr <= w_boot[NVCD_WRITE_EN_BIT];
            sec_ram <= dec_sec_ram;
            sec_flash <= flash_size(SECURE_FLASH_TABLE,
                w_sec[NVCD_FLASH_SIZE_LSB +: 3]);
            sec_wr <= w_sec[NVCD_WRITE_EN_BIT];
            gen_level <= dec_gen_level;
            gen_wr <= w_gen[NVCD_WRITE_EN_BIT];
            two_speed <= w_sel[NVCD_TWO_SPEED_BIT];
            clk_src <= w_sel[NVCD_CLK_SRC_LSB +: 3];
            switch_en <= !dec_switch_mode[1];
            fail_safe_clock_monitor_en <= dec_switch_mode == 2'h0;
            pin_lock <= w_osc[NVCD_PIN_LOCK_BIT];
            osc_clk <= !dec_crystal && w_osc[NVCD_OSC_OUT_BIT];
            osc_gpio <= !dec_crystal && !w_osc[NVCD_OSC_OUT_BIT];
            pri_mode <= dec_pri_mode;
        end
    end

    // Outputs straight from the capture flops
    assign boot_ram_size_o = boot_ram;
    assign boot_flash_protect_size_o = boot_flash;
    assign boot_write_protect_n_o = boot_wr;
    assign secure_ram_size_o = sec_ram;
    assign secure_flash_protect_size_o = sec_flash;
    assign secure_write_protect_n_o = sec_wr;
    assign general_protect_level_o = gen_level;
    assign general_write_protect_n_o = gen_wr;
    assign two_speed_startup_en_o = two_speed;
    assign initial_clock_source_o = clk_src;
    assign clock_switch_en_o = switch_en;
    assign fail_safe_clock_monitor_o = fail_safe_clock_monitor_en;
    assign pin_map_single_change_o = pin_lock;
    assign osc_out_clock_en_o = osc_clk;
    assign osc_out_gpio_en_o = osc_gpio;
    assign primary_osc_mode_o = pri_mode;

endmodule

// *** pkg/nvcd_pkg.sv ***
// Constants and types for the nonvolatile configuration word decoder
//=====================================================================
// Operation
// - Each configuration word is 24 bits; only low 16 bits can hold settings.
// - Words sit in program memory from a fixed base and stay readable at run time.
// - Programmed bits read as zero, erased bits read as one.
// - Bits 23..8 of boot, secure and oscillator words read as zero.
// - Bits 23..3 of the general segment word read as zero.
// - Boot RAM field: 11 none, 10 128 bytes, 01 256 bytes, 00 1024 bytes.
// - Boot word bit 0 one allows boot flash writes; zero write-protects it.
// - Secure RAM field: 11 none, 10 256, 01 2048, 00 4096, less boot RAM.
// - Secure word bit 0 one allows secure flash writes; zero blocks them.
// - General protect field: 11 none, 10 standard, 0x high security.
// - General word bit 0 one allows general flash writes; zero protects it.
// - Two-speed bit set starts on fast RC, then switches once source ready.
// - Three-bit initial source field selects the start-up clock source.
// - Switch mode 1x disables switch and monitor, 01 switch only, 00 both.
// - Pin-map lock bit set allows one remap; clear allows many.
// - Outside crystal modes, bit 2 gives clock out or general I/O pin.
// - Primary mode: 11 off, 10 high-speed crystal, 01 crystal, 00 external.
// - Words are programmed by self-programming, serial link or programmer.
package nvcd_pkg;

    //=================================================================
    // Address map
    localparam logic [23:0] NVCD_BASE_ADDR = 24'hf80000;
    localparam int NVCD_WORD_COUNT = 5;
    localparam int NVCD_ADDR_STEP = 2;
    localparam logic [2:0] NVCD_IDX_BOOT = 3'h0;
    localparam logic [2:0] NVCD_IDX_SECURE = 3'h1;
    localparam logic [2:0] NVCD_IDX_GENERAL = 3'h2;
    localparam logic [2:0] NVCD_IDX_OSC_SEL = 3'h3;
    localparam logic [2:0] NVCD_IDX_OSC = 3'h4;

    //=================================================================
    // Word layout and implemented-bit masks
    localparam int NVCD_WORD_W = 24;
    localparam logic [23:0] NVCD_ERASED = 24'h00ffff;
    localparam logic [23:0] NVCD_MASK_BOOT = 24'h0000cf;
    localparam logic [23:0] NVCD_MASK_SECURE = 24'h0000cf;
    localparam logic [23:0] NVCD_MASK_GENERAL = 24'h000007;
    localparam logic [23:0] NVCD_MASK_OSC_SEL = 24'h000087;
    localparam logic [23:0] NVCD_MASK_OSC = 24'h0000e7;

    //=================================================================
    // Field positions
    localparam int NVCD_RAM_SIZE_LSB = 6;
    localparam int NVCD_FLASH_SIZE_LSB = 1;
    localparam int NVCD_WRITE_EN_BIT = 0;
    localparam int NVCD_GEN_LEVEL_LSB = 1;
    localparam int NVCD_TWO_SPEED_BIT = 7;
    localparam int NVCD_CLK_SRC_LSB = 0;
    localparam int NVCD_SWITCH_MODE_LSB = 6;
    localparam int NVCD_PIN_LOCK_BIT = 5;
    localparam int NVCD_OSC_OUT_BIT = 2;
    localparam int NVCD_PRI_MODE_LSB = 0;

    //=================================================================
    // Field decodes
    localparam logic [10:0] NVCD_BOOT_RAM_NONE = 11'h000;
    localparam logic [10:0] NVCD_BOOT_RAM_128 = 11'h080;
    localparam logic [10:0] NVCD_BOOT_RAM_256 = 11'h100;
    localparam logic [10:0] NVCD_BOOT_RAM_1024 = 11'h400;
    localparam logic [12:0] NVCD_SEC_RAM_NONE = 13'h0000;
    localparam logic [12:0] NVCD_SEC_RAM_256 = 13'h0100;
    localparam logic [12:0] NVCD_SEC_RAM_2048 = 13'h0800;
    localparam logic [12:0] NVCD_SEC_RAM_4096 = 13'h1000;

    typedef enum logic [1:0] {
        NVCD_PROT_NONE = 2'h0,
        NVCD_PROT_STANDARD = 2'h1,
        NVCD_PROT_HIGH = 2'h2
    } nvcd_protect_e;

    typedef enum logic [2:0] {
        NVCD_SRC_FAST_RC = 3'h0,
        NVCD_SRC_FAST_RC_PLL = 3'h1,
        NVCD_SRC_PRIMARY = 3'h2,
        NVCD_SRC_PRIMARY_PLL = 3'h3,
        NVCD_SRC_SECONDARY = 3'h4,
        NVCD_SRC_LOW_POWER_RC = 3'h5,
        NVCD_SRC_FAST_RC_DIV16 = 3'h6,
        NVCD_SRC_FAST_RC_POST = 3'h7
    } nvcd_clk_src_e;

    typedef enum logic [1:0] {
        NVCD_PRI_EXTERNAL = 2'h0,
        NVCD_PRI_STD_CRYSTAL = 2'h1,
        NVCD_PRI_HS_CRYSTAL = 2'h2,
        NVCD_PRI_DISABLED = 2'h3
    } nvcd_pri_mode_e;

    // Programming sources
    typedef enum logic [1:0] {
        NVCD_PGM_SELF = 2'h0,
        NVCD_PGM_SERIAL = 2'h1,
        NVCD_PGM_PROGRAMMER = 2'h2
    } nvcd_pgm_src_e;

endpackage

// *** verif/nvcd_top_assertions.sv ***
// Port-level checks for the configuration word decoder
`timescale 1ns/10ps
module nvcd_top_assertions
    import nvcd_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Read port
    input wire logic rd_en_i,
    input wire logic [23:0] rd_addr_i,
    input wire logic rd_valid_o,
    input wire logic [23:0] rd_data_o,
    // Programming port
    input wire logic pgm_en_i,
    input wire logic pgm_erase_i,
    input wire logic [1:0] pgm_src_i,
    input wire logic pgm_done_o,
    input wire logic pgm_error_o,
    // Decodes
    input wire logic [10:0] boot_ram_size_o,
    input wire logic [2:0] initial_clock_source_o,
    input wire logic clock_switch_en_o,
    input wire logic fail_safe_clock_monitor_o,
    input wire logic osc_out_clock_en_o,
    input wire logic osc_out_gpio_en_o,
    input wire logic [1:0] primary_osc_mode_o
);
    //=================================================================
    // Common clocking; nothing is judged while reset is low
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // Erase wins over program, but both count as one request
    logic pgm_req;
    assign pgm_req = pgm_en_i | pgm_erase_i;

    //=================================================================
    // Properties
    property p_read_answer;
        rd_en_i |=> rd_valid_o;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_read_quiet;
        !rd_en_i |=> !rd_valid_o;
    endproperty
    a_read_quiet: assert property (p_read_quiet) else $error("stray read valid");
    property p_upper_zero;
        rd_valid_o |-> rd_data_o[23:8] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
    property p_general_bits;
        rd_en_i && rd_addr_i == NVCD_BASE_ADDR + 24'h000004 |=> rd_data_o[23:3] == 21'h000000;
    endproperty
    a_general_bits: assert property (p_general_bits) else $error("general bits set");
    property p_unmapped;
        rd_en_i && rd_addr_i[0] |=> rd_data_o == 24'h000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("odd address data");
    property p_pgm_answer;
        pgm_req |=> pgm_done_o != pgm_error_o;
    endproperty
    a_pgm_answer: assert property (p_pgm_answer) else $error("program not answered");
    property p_pgm_refuse;
        pgm_req && pgm_src_i == 2'h3 |=> pgm_error_o && !pgm_done_o;
    endproperty
    a_pgm_refuse: assert property (p_pgm_refuse) else $error("bad source taken");
    property p_pgm_quiet;
        !pgm_req |=> !pgm_done_o && !pgm_error_o;
    endproperty
    a_pgm_quiet: assert property (p_pgm_quiet) else $error("stray program status");
    property p_decode_hold;
        reset_n_i |=> $stable(boot_ram_size_o) && $stable(initial_clock_source_o)
            && $stable(primary_osc_mode_o) && $stable(clock_switch_en_o);
    endproperty
    a_decode_hold: assert property (p_decode_hold) else $error("decode moved");
    property p_monitor_switch;
        fail_safe_clock_monitor_o |-> clock_switch_en_o;
    endproperty
    a_monitor_switch: assert property (p_monitor_switch) else $error("monitor alone");
    property p_osc_pin;
        primary_osc_mode_o == 2'h1 || primary_osc_mode_o == 2'h2
            |-> !(osc_out_clock_en_o || osc_out_gpio_en_o);
    endproperty
    a_osc_pin: assert property (p_osc_pin) else $error("pin used in crystal mode");
endmodule

bind nvcd_top nvcd_top_assertions u_nvcd_top_assertions
(
    .clk_i(clk_i), .reset_n_i(reset_n_i), .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .pgm_en_i(pgm_en_i),
    .pgm_erase_i(pgm_erase_i), .pgm_src_i(pgm_src_i), .pgm_done_o(pgm_done_o),
    .pgm_error_o(pgm_error_o), .boot_ram_size_o(boot_ram_size_o),
    .initial_clock_source_o(initial_clock_source_o), .clock_switch_en_o(clock_switch_en_o),
    .fail_safe_clock_monitor_o(fail_safe_clock_monitor_o),
    .osc_out_clock_en_o(osc_out_clock_en_o), .osc_out_gpio_en_o(osc_out_gpio_en_o),
    .primary_osc_mode_o(primary_osc_mode_o)
);

// *** verif/nvcd_top_tb.sv ***
// Self-checking bench for the configuration word decoder
`timescale 1ns/10ps
module nvcd_top_tb
    import nvcd_pkg::*;
;
    //=================================================================
    // Parameters and signals
    localparam int FW = 16;
    // Distinct table entries so a wrong index shows up
    localparam logic [8*FW-1:0] BOOT_TBL = 128'h0008_0007_0006_0005_0004_0003_0002_0001;
    localparam logic [8*FW-1:0] SEC_TBL = 128'h0017_0016_0015_0014_0013_0012_0011_0010;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic rd_en_i = 1'b0;
    logic [23:0] rd_addr_i = 24'h000000;
    logic pgm_en_i = 1'b0;
    logic pgm_erase_i = 1'b0;
    logic [1:0] pgm_src_i = 2'h0;
    logic [23:0] pgm_addr_i = 24'h000000;
    logic [23:0] pgm_data_i = 24'h000000;
    logic rd_valid_o, pgm_done_o, pgm_error_o, boot_write_protect_n_o, secure_write_protect_n_o;
    logic general_write_protect_n_o, two_speed_startup_en_o, clock_switch_en_o;
    logic fail_safe_clock_monitor_o, pin_map_single_change_o, osc_out_clock_en_o;
    logic osc_out_gpio_en_o;
    logic [23:0] rd_data_o;
    logic [10:0] boot_ram_size_o;
    logic [12:0] secure_ram_size_o;
    logic [FW-1:0] boot_flash_protect_size_o, secure_flash_protect_size_o;
    logic [1:0] general_protect_level_o, primary_osc_mode_o;
    logic [2:0] initial_clock_source_o;
    logic [63:0] prot_seen, osc_seen, held_prot, held_osc;
    // Model of the stored words; cells start erased
    logic [23:0] words [5] = '{default: 24'h00ffff};
    logic [23:0] masks [5] = '{24'h0000cf, 24'h0000cf, 24'h000007, 24'h000087, 24'h0000e7};
    integer seed = 32'hf05a;
    int mismatches = 0;
    int comparisons = 0;

    initial
    begin
        forever #10 clk_i = ~clk_i;
    end

    nvcd_top #(.FLASH_SIZE_W(FW), .BOOT_FLASH_TABLE(BOOT_TBL), .SECURE_FLASH_TABLE(SEC_TBL))
    u_nvcd_top (.clk_i(clk_i), .reset_n_i(reset_n_i), .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i),
        .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .pgm_en_i(pgm_en_i),
        .pgm_erase_i(pgm_erase_i), .pgm_src_i(pgm_src_i), .pgm_addr_i(pgm_addr_i),
        .pgm_data_i(pgm_data_i), .pgm_done_o(pgm_done_o), .pgm_error_o(pgm_error_o),
        .boot_ram_size_o(boot_ram_size_o), .boot_flash_protect_size_o(boot_flash_protect_size_o),
        .boot_write_protect_n_o(boot_write_protect_n_o), .secure_ram_size_o(secure_ram_size_o),
        .secure_flash_protect_size_o(secure_flash_protect_size_o),
        .secure_write_protect_n_o(secure_write_protect_n_o),
        .general_protect_level_o(general_protect_level_o),
        .general_write_protect_n_o(general_write_protect_n_o),
        .two_speed_startup_en_o(two_speed_startup_en_o),
        .initial_clock_source_o(initial_clock_source_o), .clock_switch_en_o(clock_switch_en_o),
        .fail_safe_clock_monitor_o(fail_safe_clock_monitor_o),
        .pin_map_single_change_o(pin_map_single_change_o),
        .osc_out_clock_en_o(osc_out_clock_en_o), .osc_out_gpio_en_o(osc_out_gpio_en_o),
        .primary_osc_mode_o(primary_osc_mode_o));

    // Decodes packed so one compare covers a whole group
    assign prot_seen = {3'h0, boot_ram_size_o, boot_flash_protect_size_o, boot_write_protect_n_o,
        secure_ram_size_o, secure_flash_protect_size_o, secure_write_protect_n_o,
        general_protect_level_o, general_write_protect_n_o};
    assign osc_seen = {53'h0, two_speed_startup_en_o, initial_clock_source_o, clock_switch_en_o,
        fail_safe_clock_monitor_o, pin_map_single_change_o, osc_out_clock_en_o,
        osc_out_gpio_en_o, primary_osc_mode_o};

    //=================================================================
    // Expectations
    function automatic logic mapped(input logic [23:0] a);
        return a[0] == 1'b0 && a >= NVCD_BASE_ADDR && a < NVCD_BASE_ADDR + 24'h00000a;
    endfunction

    function automatic logic [63:0] exp_prot();
        logic [10:0] b;
        logic [12:0] s;
        logic [1:0] g;
        b = (words[0][7:6] == 2'h3) ? 11'h000 : (words[0][7:6] == 2'h2) ? 11'h080
            : (words[0][7:6] == 2'h1) ? 11'h100 : 11'h400;
        s = (words[1][7:6] == 2'h3) ? 13'h0000 : (words[1][7:6] == 2'h2) ? 13'h0100
            : (words[1][7:6] == 2'h1) ? 13'h0800 : 13'h1000;
        g = (words[2][2:1] == 2'h3) ? 2'h0 : (words[2][2:1] == 2'h2) ? 2'h1 : 2'h2;
        // Boot RAM is carved out of the secure RAM, never below zero
        s = (s > {2'h0, b}) ? s - {2'h0, b} : 13'h0000;
        return {3'h0, b, BOOT_TBL[words[0][3:1]*FW +: FW], words[0][0], s,
            SEC_TBL[words[1][3:1]*FW +: FW], words[1][0], g, words[2][0]};
    endfunction

    function automatic logic [63:0] exp_osc();
        logic xtal;
        xtal = (words[4][1:0] == 2'h1) || (words[4][1:0] == 2'h2);
        return {53'h0, words[3][7], words[3][2:0], !words[4][7], words[4][7:6] == 2'h0,
            words[4][5], words[4][2] && !xtal, !words[4][2] && !xtal, words[4][1:0]};
    endfunction

    //=================================================================
    // Drivers and comparison; each driver starts at a falling edge
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic do_read(input logic [23:0] addr);
        logic [23:0] exp;
        int idx;
        idx = int'((addr - NVCD_BASE_ADDR) >> 1);
        exp = mapped(addr) ? words[idx] & masks[idx] : 24'h000000;
        rd_en_i = 1'b1;
        rd_addr_i = addr;
        @(posedge clk_i);
        @(negedge clk_i);
        check({63'h0, rd_valid_o}, 64'h1);
        check({40'h0, rd_data_o}, {40'h0, exp});
    endtask

    task automatic read_all();
        for (int k = 0; k < 5; k++)
            do_read(NVCD_BASE_ADDR + 24'(2 * k));
        do_read(NVCD_BASE_ADDR + 24'h000001);
        do_read(NVCD_BASE_ADDR + 24'h00000a);
        do_read(NVCD_BASE_ADDR - 24'h000002);
    endtask

    task automatic do_pgm(input logic erase, input logic [1:0] src, input logic [23:0] addr,
        input logic [23:0] data);
        logic ok;
        ok = (src != 2'h3) && mapped(addr);
        pgm_en_i = ~erase;
        pgm_erase_i = erase;
        pgm_src_i = src;
        pgm_addr_i = addr;
        pgm_data_i = data;
        @(posedge clk_i);
        if (ok && erase)
            words = '{default: 24'h00ffff};
        else if (ok)
            words[(addr - NVCD_BASE_ADDR) >> 1] &= data | 24'hff0000;
        @(negedge clk_i);
        // Strobes stay up here; the caller drops them once a burst ends
        check({62'h0, pgm_done_o, pgm_error_o}, {62'h0, ok, !ok});
    endtask

    task automatic do_reset(input int n);
        rd_en_i = 1'b0;
        reset_n_i = 1'b0;
        repeat (n) @(negedge clk_i);
        reset_n_i = 1'b1;
        check(prot_seen, exp_prot());
        check(osc_seen, exp_osc());
        held_prot = exp_prot();
        held_osc = exp_osc();
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    //=================================================================
    // Main sequence: first eight rounds walk every field code, the rest are random
    initial
    begin
        logic [31:0] x;
        logic [31:0] rv;
        logic [1:0] src;
        logic [7:0] lb;
        do_reset(5);
        read_all();
        for (int r = 0; r < 32; r++)
        begin
            rv = $random(seed);
            src = (rv[1:0] == 2'h3) ? 2'h0 : rv[1:0];
            do_pgm(1'b1, src, NVCD_BASE_ADDR, rv[31:8]);
            for (int k = 0; k < 5; k++)
            begin
                rv = $random(seed);
                // Secure word offset by two so boot 1024 meets secure 256
                x = (r < 8) ? 32'(r + ((k == 1) ? 2 : 0)) : rv;
                lb = {x[1:0], x[2:0], x[2:0]};
                do_pgm(1'b0, src, NVCD_BASE_ADDR + 24'(2 * k), {rv[31:16], lb});
            end
            // Refused requests carry all-zero data so a wrong accept is visible
            do_pgm(1'b0, 2'h3, NVCD_BASE_ADDR, 24'h000000);
            do_pgm(1'b0, src, NVCD_BASE_ADDR + 24'h000003, 24'h000000);
            pgm_en_i = 1'b0;
            read_all();
            rd_en_i = 1'b0;
            @(negedge clk_i);
            check({63'h0, rd_valid_o}, 64'h0);
            // Words were rewritten, yet decodes must keep the last reset's capture
            check(prot_seen, held_prot);
            check(osc_seen, held_osc);
            do_reset(2);
        end
        complete_run();
    end

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        complete_run();
    end
endmodule
